// File: aqc_params.svh
// Purpose: offsets, field positions and reset values for the acquisition control
// Assumes: byte-wide device registers, 32-bit APB on the controller
// Notes: definitions only
`ifndef AQC_PARAMS_SVH
`define AQC_PARAMS_SVH
// Device byte offsets
`define AQC_OFS_TMR0 4'h0
`define AQC_OFS_TMR1 4'h1
`define AQC_OFS_TMR2 4'h2
`define AQC_OFS_TMRCTL 4'h3
`define AQC_OFS_DATLO 4'h4
`define AQC_OFS_DATHI 4'h5
`define AQC_OFS_IRQCLR 4'h8
`define AQC_OFS_GAIN 4'h9
`define AQC_OFS_CHAN 4'ha
`define AQC_OFS_MODE 4'hb
`define AQC_OFS_SWTRIG 4'hc
// Field positions
`define AQC_BUSY_BIT 4
`define AQC_MODE_SW_POLL 3'h1
`define AQC_MODE_PACER_INT 3'h6
`define AQC_IRQ_UNUSED 3'h1
`define AQC_MODE_RST 8'h00
// Controller APB byte addresses
`define AQC_APB_CMD 8'h00
`define AQC_APB_RESULT 8'h04
`define AQC_APB_IRQ 8'h08
`define AQC_CMD_ADDR_LSB 16
`define AQC_CMD_OP_LSB 24
`define AQC_RES_BUSY_BIT 31
`endif

// File: aqc_pkg.sv
// Purpose: shared types of the acquisition control
// Assumes: nothing
// Notes: state codes are Gray from idle through poll to low; the step back to idle flips two bits
package aqc_pkg;
  typedef enum logic [1:0] {
    AQC_OP_WRITE = 2'h0,
    AQC_OP_READ = 2'h1,
    AQC_OP_DAC = 2'h2,
    AQC_OP_ACQ = 2'h3
  } aqc_op_type;
  typedef enum logic [2:0] {
    AQC_H_IDLE = 3'h0,
    AQC_H_FIRST = 3'h1,
    AQC_H_SECOND = 3'h3,
    AQC_H_POLL = 3'h2,
    AQC_H_LOW = 3'h6
  } aqc_hstate_type;
endpackage

// File: aqc_bus_if.sv
// Purpose: byte-wide register port between host controller and device
// Assumes: both ends on sys_clk
// Notes: read data answers one cycle after the read strobe
`timescale 1ns/1ps
interface aqc_bus_if;
  logic [3:0] regAddr;
  logic [7:0] regWrData;
  logic regWr;
  logic regRd;
  logic [7:0] regRdData;
  logic regRdValid;
  logic [7:0] irqReq;
  modport dev (
    input regAddr, regWrData, regWr, regRd,
    output regRdData, regRdValid, irqReq
  );
  modport host (
    output regAddr, regWrData, regWr, regRd,
    input regRdData, regRdValid, irqReq
  );
endinterface

// File: aqc_device.sv
// Purpose: acquisition card logic: pacer timer, converter control, D/A latch
// Assumes: converter handshake on sys_clk; diffMode is an external jumper
// Notes: byte registers reached through aqc_bus_if
//
// The byte register port was decided locally.
`timescale 1ns/1ps
`include "aqc_params.svh"
module aqc_device import aqc_pkg::*; #(
  parameter int TICK_DIV = 63
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port
  aqc_bus_if.dev bus,
  // Jumper
  input wire logic diffMode,
  // Converter
  output logic convStart,
  input wire logic convDone,
  input wire logic [11:0] convData,
  // Analog front end and D/A
  output logic [1:0] adcGain,
  output logic [3:0] adcChannel,
  output logic [11:0] dacValue
);
  logic diffMeta_q, diffSync_q;
  logic [7:0] modeReg_q, gainReg_q, chanReg_q, dacLow_q, rdData_q;
  logic [11:0] result_q, dacValue_q;
  logic busy_q, intStat_q, rdValid_q, convStart_q;
  logic [15:0] reload_q [3];
  logic [15:0] count_q [3];
  logic [2:0] hiNext_q;
  logic [$clog2(TICK_DIV+1)-1:0] div_q;
  logic tick, cnt1Wrap, pacerTrig, swTrig, trigAccept, pacerMode, swMode, intMode;
  logic wrDatLo, wrDatHi, wrMode, wrGain, wrChan, wrCtl, wrClr;
  logic [7:0] rdByte, irqVec;

  // Write decode
  assign wrDatLo = bus.regWr && bus.regAddr == `AQC_OFS_DATLO;
  assign wrDatHi = bus.regWr && bus.regAddr == `AQC_OFS_DATHI;
  assign wrMode = bus.regWr && bus.regAddr == `AQC_OFS_MODE;
  assign wrGain = bus.regWr && bus.regAddr == `AQC_OFS_GAIN;
  assign wrChan = bus.regWr && bus.regAddr == `AQC_OFS_CHAN;
  assign wrCtl = bus.regWr && bus.regAddr == `AQC_OFS_TMRCTL;
  assign wrClr = bus.regWr && bus.regAddr == `AQC_OFS_IRQCLR;
  assign swTrig = bus.regWr && bus.regAddr == `AQC_OFS_SWTRIG && swMode;

  // mode decode; software for codes 0 and 1, pacer whenever bit 1 is set, interrupt for code 6
  assign swMode = modeReg_q[2:1] == 2'h0;
  assign pacerMode = modeReg_q[1];
  assign intMode = modeReg_q[2:0] == `AQC_MODE_PACER_INT;

  // Jumper crosses from outside, two flops
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      diffMeta_q <= 1'b0;
      diffSync_q <= 1'b0;
    end else begin
      diffMeta_q <= diffMode;
      diffSync_q <= diffMeta_q;
    end
  end

  // Control registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      modeReg_q <= `AQC_MODE_RST;
      gainReg_q <= 8'h00;
      chanReg_q <= 8'h00;
    end else begin
      if (wrMode)
        modeReg_q <= bus.regWrData;
      if (wrGain)
        gainReg_q <= bus.regWrData;
      if (wrChan)
        chanReg_q <= bus.regWrData;
    end
  end
  assign adcGain = gainReg_q[1:0];
  // mux select; bit three dropped when differential
  assign adcChannel = diffSync_q ? {1'b0, chanReg_q[2:0]} : chanReg_q[3:0];

  // Timer tick divider, the pacer counts these slow enables
  always_ff @(posedge sys_clk) begin
    if (!rst_b)
      div_q <= '0;
    else if (tick)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end
  assign tick = div_q == ($clog2(TICK_DIV+1))'(TICK_DIV - 1);

  // per-counter ports: low byte then high byte; in pacer mode counter two's writes do not load its count, counter one's high write does
  // counter zero is held and readable only, never counts
  for (genvar i = 0; i < 3; i++) begin : gCnt
    logic wrPort, selCtl;
    assign wrPort = bus.regWr && bus.regAddr == 4'(i);
    assign selCtl = wrCtl && bus.regWrData[7:6] == 2'(i);
    always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
        reload_q[i] <= 16'h0000;
        hiNext_q[i] <= 1'b0;
      end else if (selCtl) begin
        hiNext_q[i] <= 1'b0;
      end else if (wrPort) begin
        hiNext_q[i] <= !hiNext_q[i];
        if (hiNext_q[i])
          reload_q[i][15:8] <= bus.regWrData;
        else
          reload_q[i][7:0] <= bus.regWrData;
      end
    end
  end

  // counter one wraps into counter two; a zero reload means 65536
  assign cnt1Wrap = pacerMode && tick && count_q[1] == 16'h0001;
  assign pacerTrig = cnt1Wrap && count_q[2] == 16'h0001;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      count_q[0] <= 16'h0000;
      count_q[1] <= 16'h0000;
      count_q[2] <= 16'h0000;
    end else begin
      count_q[0] <= reload_q[0];
      if (!pacerMode || (bus.regWr && bus.regAddr == `AQC_OFS_TMR1 && hiNext_q[1]))
        count_q[1] <= {bus.regWr && bus.regAddr == `AQC_OFS_TMR1 && hiNext_q[1] ?
                       bus.regWrData : reload_q[1][15:8], reload_q[1][7:0]};
      else if (cnt1Wrap)
        count_q[1] <= reload_q[1];
      else if (tick)
        count_q[1] <= count_q[1] - 16'h0001;
      if (!pacerMode)
        count_q[2] <= reload_q[2];
      else if (pacerTrig)
        count_q[2] <= reload_q[2];
      else if (cnt1Wrap)
        count_q[2] <= count_q[2] - 16'h0001;
    end
  end

  // only a trigger starts; ignored while busy
  assign trigAccept = (swTrig || pacerTrig) && !busy_q;

  // busy from accept until result stored; result capture
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      convStart_q <= 1'b0;
      result_q <= 12'h000;
    end else begin
      convStart_q <= trigAccept;
      if (trigAccept)
        busy_q <= 1'b1;
      else if (busy_q && convDone) begin
        busy_q <= 1'b0;
        result_q <= convData;
      end
    end
  end
  assign convStart = convStart_q;

  // sticky status, set wins over clear; only in interrupt mode
  always_ff @(posedge sys_clk) begin
    if (!rst_b)
      intStat_q <= 1'b0;
    else if (intMode && busy_q && convDone)
      intStat_q <= 1'b1;
    else if (wrClr)
      intStat_q <= 1'b0;
  end
  // line select; code 1 drives no line, codes 0 and 2 both line two
  always_comb begin
    irqVec = 8'h00;
    if (modeReg_q[6:4] == 3'h0)
      irqVec[2] = intStat_q;
    else if (modeReg_q[6:4] != `AQC_IRQ_UNUSED)
      irqVec[modeReg_q[6:4]] = intStat_q;
  end
  assign bus.irqReq = irqVec;

  // D/A shares offsets 4 and 5 on writes
  // only the high write moves the output, low byte is held
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      dacLow_q <= 8'h00;
      dacValue_q <= 12'h000;
    end else begin
      if (wrDatLo)
        dacLow_q <= bus.regWrData;
      if (wrDatHi)
        dacValue_q <= {bus.regWrData[3:0], dacLow_q};
    end
  end
  assign dacValue = dacValue_q;

  // Read mux; busy in bit 4 of high byte, low valid once clear
  always_comb begin
    rdByte = 8'h00;
    if (bus.regAddr == `AQC_OFS_DATLO)
      rdByte = result_q[7:0];
    else if (bus.regAddr == `AQC_OFS_DATHI)
      rdByte = {3'h0, busy_q, result_q[11:8]};
    else if (bus.regAddr < `AQC_OFS_TMRCTL)
      rdByte = hiNext_q[bus.regAddr[1:0]] ? count_q[bus.regAddr[1:0]][15:8] :
               count_q[bus.regAddr[1:0]][7:0];
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rdData_q <= 8'h00;
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= bus.regRd;
      if (bus.regRd)
        rdData_q <= rdByte;
    end
  end
  assign bus.regRdData = rdData_q;
  assign bus.regRdValid = rdValid_q;
endmodule

// File: aqc_host.sv
// Purpose: host-side controller, APB commands turned into device byte accesses
// Assumes: device answers reads one cycle after the strobe
// Notes: settling delays are left to software
`timescale 1ns/1ps
`include "aqc_params.svh"
module aqc_host import aqc_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device side
  aqc_bus_if.host bus
);
  aqc_hstate_type state_q;
  aqc_op_type op_q;
  logic [3:0] addr_q, busAddr_q;
  logic [11:0] data_q, result_q;
  logic [7:0] busData_q, hiByte_q;
  logic wr_q, rd_q;
  logic apbWr, cmdWr, hit;

  // APB decode, one-cycle answer
  assign apbWr = psel && penable && pwrite;
  assign cmdWr = apbWr && paddr == `AQC_APB_CMD && state_q == AQC_H_IDLE;
  assign hit = paddr == `AQC_APB_CMD || paddr == `AQC_APB_RESULT || paddr == `AQC_APB_IRQ;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = paddr == `AQC_APB_RESULT ?
                  {state_q != AQC_H_IDLE, 19'h00000, result_q} :
                  paddr == `AQC_APB_IRQ ? {24'h000000, bus.irqReq} : 32'h00000000;

  // Sequencer; a command while busy is dropped
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= AQC_H_IDLE;
      op_q <= AQC_OP_WRITE;
      addr_q <= 4'h0;
      data_q <= 12'h000;
      result_q <= 12'h000;
      hiByte_q <= 8'h00;
      busAddr_q <= 4'h0;
      busData_q <= 8'h00;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      case (state_q)
        AQC_H_IDLE: begin
          if (cmdWr) begin
            op_q <= aqc_op_type'(pwdata[`AQC_CMD_OP_LSB +: 2]);
            addr_q <= pwdata[`AQC_CMD_ADDR_LSB +: 4];
            data_q <= pwdata[11:0];
            state_q <= AQC_H_FIRST;
          end
        end
        AQC_H_FIRST: begin
          busAddr_q <= addr_q;
          busData_q <= data_q[7:0];
          if (op_q == AQC_OP_READ) begin
            rd_q <= 1'b1;
            state_q <= AQC_H_LOW;
          end else begin
            wr_q <= 1'b1;
            if (op_q == AQC_OP_DAC)
              busAddr_q <= `AQC_OFS_DATLO;
            if (op_q == AQC_OP_ACQ)
              busAddr_q <= `AQC_OFS_SWTRIG;
            state_q <= op_q == AQC_OP_WRITE ? AQC_H_IDLE : AQC_H_SECOND;
          end
        end
        AQC_H_SECOND: begin
          busAddr_q <= `AQC_OFS_DATHI;
          busData_q <= {4'h0, data_q[11:8]};
          if (op_q == AQC_OP_DAC) begin
            wr_q <= 1'b1;
            state_q <= AQC_H_IDLE;
          end else begin
            rd_q <= 1'b1;
            state_q <= AQC_H_POLL;
          end
        end
        AQC_H_POLL: begin
          // poll high byte until busy clear, then low
          if (bus.regRdValid) begin
            rd_q <= 1'b1;
            hiByte_q <= bus.regRdData;
            if (!bus.regRdData[`AQC_BUSY_BIT]) begin
              busAddr_q <= `AQC_OFS_DATLO;
              state_q <= AQC_H_LOW;
            end
          end
        end
        default: begin
          if (bus.regRdValid) begin
            result_q <= op_q == AQC_OP_ACQ ? {hiByte_q[3:0], bus.regRdData} :
                        {4'h0, bus.regRdData};
            state_q <= AQC_H_IDLE;
          end
        end
      endcase
    end
  end
  assign bus.regAddr = busAddr_q;
  assign bus.regWrData = busData_q;
  assign bus.regWr = wr_q;
  assign bus.regRd = rd_q;
endmodule

// File: aqc_bus_monitor.sv
// Purpose: watches the byte port between host controller and device
// Assumes: one clock, synchronous active-low reset
// Notes: sees only the carrier's signals, converter side is judged by the bench
`timescale 1ns/1ps
`include "aqc_params.svh"
module aqc_bus_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Byte port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  input wire logic [7:0] irqReq
);
  logic [3:0] rdAddr_q;
  // Offset of the read being answered, kept because the answer lags a cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rdAddr_q <= 4'h0;
    end else if (regRd) begin
      rdAddr_q <= regAddr;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_rd_answer;
    regRd |=> regRdValid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read strobe not answered");
  property p_rd_cause;
    regRdValid |-> $past(regRd);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("answer without a read");
  property p_rd_hold;
    !regRd |=> $stable(regRdData);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
  property p_hi_zero;
    regRdValid && rdAddr_q == `AQC_OFS_DATHI |-> regRdData[7:5] == 3'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("high byte top bits not zero");
  property p_busy_set;
    regWr && regAddr == `AQC_OFS_SWTRIG ##1 regRd && regAddr == `AQC_OFS_DATHI
      |=> regRdData[`AQC_BUSY_BIT];
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy clear after trigger");
  property p_unmapped;
    regRdValid && (rdAddr_q == 4'h6 || rdAddr_q == 4'h7) |-> regRdData == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped offset read nonzero");
  property p_irq_one;
    $onehot0(irqReq);
  endproperty
  a_irq_one: assert property (p_irq_one) else $error("more than one interrupt line");
  property p_irq_low;
    irqReq[1:0] == 2'h0;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("interrupt on a line never offered");
  property p_irq_fall;
    $fell(|irqReq) |-> $past(regWr);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped on its own");
  // Main scenarios reached
  c_trig: cover property (regWr && regAddr == `AQC_OFS_SWTRIG);
  c_irq: cover property ($rose(|irqReq));
  c_dachi: cover property (regWr && regAddr == `AQC_OFS_DATHI && regWrData[3:0] != 4'h0);
endmodule

// File: tb_adc_dac_acquisition_control.sv
// Purpose: drives the host controller over APB and the device's converter side
// Assumes: pacer ticks shortened to two clocks
// Notes: converter stand-in answers after convDelay cycles with convData
`timescale 1ns/1ps
`include "aqc_params.svh"
module tb_adc_dac_acquisition_control import aqc_pkg::*;;
  localparam int TickDiv = 2;
  logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, lastErr;
  logic diffMode, convStart, convDone;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [11:0] convData, dacValue;
  logic [1:0] adcGain;
  logic [3:0] adcChannel;
  int num_errors, cmp_count, cycles, convCnt, convDelay, startCnt, lastStart, period, s0;
  aqc_bus_if i_aqc_bus_if ();
  aqc_device #(.TICK_DIV(TickDiv)) i_aqc_device (.sys_clk(sys_clk), .rst_b(rst_b),
    .bus(i_aqc_bus_if), .diffMode(diffMode), .convStart(convStart), .convDone(convDone),
    .convData(convData), .adcGain(adcGain), .adcChannel(adcChannel), .dacValue(dacValue));
  aqc_host i_aqc_host (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(i_aqc_bus_if));
  aqc_bus_monitor i_aqc_bus_monitor (.sys_clk(sys_clk), .rst_b(rst_b),
    .regAddr(i_aqc_bus_if.regAddr), .regWrData(i_aqc_bus_if.regWrData),
    .regWr(i_aqc_bus_if.regWr), .regRd(i_aqc_bus_if.regRd),
    .regRdData(i_aqc_bus_if.regRdData), .regRdValid(i_aqc_bus_if.regRdValid),
    .irqReq(i_aqc_bus_if.irqReq));
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Converter stand-in and pacer period measurement
  always @(posedge sys_clk) begin
    convDone <= (convCnt == 1);
    if (convStart) begin
      convCnt <= convDelay;
      startCnt <= startCnt + 1;
      lastStart <= cycles;
      period <= cycles - lastStart;
    end else if (convCnt > 0) begin
      convCnt <= convCnt - 1;
    end
  end
  // Hang guard, far above the thousand or so cycles the tests need
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      $display("unexpected at %0t: timeout", $time);
      stop_test();
    end
  end
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Command word, then poll until the sequencer is idle; r holds the result
  task automatic cmd(input logic [1:0] op, input logic [3:0] ofs, input logic [11:0] d);
    apb(1'b1, `AQC_APB_CMD, {6'h00, op, 4'h0, ofs, 4'h0, d});
    do apb(1'b0, `AQC_APB_RESULT, 32'h0); while (r[31] !== 1'b0);
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, diffMode, convDone, convData} = '0;
    {num_errors, cmp_count, cycles, convCnt, startCnt, lastStart, period} = '0;
    convDelay = 12;
    rst_b = 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    check(dacValue, 12'h000, "dac reset");
    check(i_aqc_bus_if.irqReq, 8'h00, "irq reset");
    apb(1'b0, 8'h0c, 32'h0);
    check(lastErr, 1'b1, "unmapped apb");
    $display("test reset done");
    cmd(AQC_OP_WRITE, `AQC_OFS_MODE, 12'h001);
    cmd(AQC_OP_WRITE, `AQC_OFS_GAIN, 12'h0ff);
    check(adcGain, 2'h3, "gain");
    for (int m = 0; m < 2; m++) begin
      diffMode <= m[0];
      repeat (4) @(posedge sys_clk);
      cmd(AQC_OP_WRITE, `AQC_OFS_CHAN, 12'h0fd);
      check(adcChannel, m[0] ? 4'h5 : 4'hd, "channel");
    end
    check(startCnt, 0, "no trigger yet");
    $display("test setup done");
    convData <= 12'ha5c;
    // Front end settles before the strobe, the device does not wait itself
    repeat (8) @(posedge sys_clk);
    cmd(AQC_OP_ACQ, 4'h0, 12'h000);
    check(r[11:0], 12'ha5c, "acquired");
    check(startCnt, 1, "one start");
    cmd(AQC_OP_READ, `AQC_OFS_DATHI, 12'h000);
    check(r[7:0], 8'h0a, "high byte");
    cmd(AQC_OP_READ, `AQC_OFS_DATLO, 12'h000);
    check(r[7:0], 8'h5c, "low byte");
    cmd(AQC_OP_READ, 4'h6, 12'h000);
    check(r[7:0], 8'h00, "unmapped byte");
    $display("test acquire done");
    convDelay = 60;
    cmd(AQC_OP_WRITE, `AQC_OFS_SWTRIG, 12'h0a5);
    cmd(AQC_OP_READ, `AQC_OFS_DATHI, 12'h000);
    check(r[4], 1'b1, "busy during conversion");
    cmd(AQC_OP_WRITE, `AQC_OFS_SWTRIG, 12'h03c);
    check(startCnt, 2, "retrigger ignored");
    repeat (70) @(posedge sys_clk);
    cmd(AQC_OP_READ, `AQC_OFS_DATHI, 12'h000);
    check(r[4], 1'b0, "busy cleared");
    $display("test retrigger done");
    cmd(AQC_OP_DAC, 4'h0, 12'habc);
    check(dacValue, 12'habc, "dac both");
    cmd(AQC_OP_WRITE, `AQC_OFS_DATHI, 12'h0f5);
    check(dacValue, 12'h5bc, "dac high only");
    cmd(AQC_OP_WRITE, `AQC_OFS_DATLO, 12'h011);
    check(dacValue, 12'h5bc, "dac late low");
    cmd(AQC_OP_WRITE, `AQC_OFS_DATHI, 12'h007);
    check(dacValue, 12'h711, "dac next high");
    $display("test dac done");
    convDelay = 3;
    cmd(AQC_OP_WRITE, `AQC_OFS_TMR0, 12'h034);
    cmd(AQC_OP_WRITE, `AQC_OFS_TMR0, 12'h012);
    cmd(AQC_OP_WRITE, `AQC_OFS_TMR1, 12'h008);
    cmd(AQC_OP_WRITE, `AQC_OFS_TMR1, 12'h000);
    cmd(AQC_OP_WRITE, `AQC_OFS_TMR2, 12'h004);
    cmd(AQC_OP_WRITE, `AQC_OFS_TMR2, 12'h000);
    s0 = startCnt;
    cmd(AQC_OP_WRITE, `AQC_OFS_MODE, 12'h036);
    while (startCnt < s0 + 3) @(posedge sys_clk);
    check(period, 32 * TickDiv, "pacer period");
    check(i_aqc_bus_if.irqReq, 8'h08, "irq line");
    cmd(AQC_OP_WRITE, `AQC_OFS_IRQCLR, 12'h000);
    apb(1'b0, `AQC_APB_IRQ, 32'h0);
    check(r, 32'h0, "irq cleared");
    while (i_aqc_bus_if.irqReq === 8'h00) @(posedge sys_clk);
    check(i_aqc_bus_if.irqReq, 8'h08, "irq again");
    cmd(AQC_OP_WRITE, `AQC_OFS_MODE, 12'h001);
    cmd(AQC_OP_WRITE, `AQC_OFS_IRQCLR, 12'h000);
    s0 = startCnt;
    repeat (200) @(posedge sys_clk);
    check(startCnt, s0, "pacer off");
    check(i_aqc_bus_if.irqReq, 8'h00, "no irq in poll mode");
    // Counter zero keeps its load through the whole pacer run
    cmd(AQC_OP_READ, `AQC_OFS_TMR0, 12'h000);
    check(r[7:0], 8'h34, "counter zero held");
    // Pacer off, counter one shows its reload low byte
    cmd(AQC_OP_READ, `AQC_OFS_TMR1, 12'h000);
    check(r[7:0], 8'h08, "counter one low");
    $display("test pacer done");
    stop_test();
  end
endmodule
